// file: include/sfr_defines.vh
// Behaviour
// - after enable the receiver discards line bits until a flag is seen.
// - receiver returns to hunt only when software sets the hunt bit or clears the enable or SDLC mode bit.
// - with address search on, first character must match address or FF.
// - only one address byte is matched; later bytes pass as data.
// - hunt bit set mid-frame drops the frame and waits for a flag.
// - stuffed zeros removed, flags never stored, control field is data.
// - after a flag each character of an accepted frame is written to the FIFO unless the FIFO is full and not read in the same cycle.
// - first-character mode interrupts once, rearmed by a command.
// - external/status interrupt on each carrier detect change.
// - every-character mode interrupts while the FIFO holds data.
// - overrun or end of frame interrupts only in a receive mode.
// - overrun bit is sticky until the error reset command.
// - end of frame set at closing flag with CRC and residue valid.
// - character length may change while a character is assembled.
// - CRC restarts at the leading flag and covers all bits.
// - frame good when remainder is 1D0F, else CRC error at end.
// - the two CRC bytes reach the FIFO as data; host drops them.
// - three-bit residue code reported at end of frame.
// - seven ones are an abort: abort bit and external interrupt.
// - a second external interrupt follows when the ones run ends.
// - CRC result is complete when the last CRC byte is stored.
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH
`define SFR_A_LINE_MODE  8'h00
`define SFR_A_INT_CTRL   8'h04
`define SFR_A_RX_CTRL    8'h08
`define SFR_A_SEC_ADDR   8'h0C
`define SFR_A_FLAG       8'h10
`define SFR_A_CMD        8'h14
`define SFR_A_STAT1      8'h18
`define SFR_A_STAT2      8'h1C
`define SFR_A_DATA       8'h20
`define SFR_A_INT_STAT   8'h24
`define SFR_LM_SDLC      1
`define SFR_IC_EXT_EN    0
`define SFR_IC_SAV       1
`define SFR_IC_ADDR_SRCH 2
`define SFR_IC_MODE_LO   3
`define SFR_IC_MODE_HI   4
`define SFR_RC_EN        0
`define SFR_RC_LEN_LO    1
`define SFR_RC_LEN_HI    2
`define SFR_RC_HUNT      4
`define SFR_CMD_ERR_RST  0
`define SFR_CMD_EXT_RST  1
`define SFR_CMD_ARM      2
`define SFR_MODE_NONE    2'h0
`define SFR_MODE_FIRST   2'h1
`define SFR_MODE_EVERY   2'h2
`define SFR_FLAG_RST     8'h7E
`define SFR_GLOBAL_ADDR  8'hFF
`define SFR_CRC_INIT     16'hFFFF
`define SFR_CRC_POLY     16'h1021
`define SFR_CRC_GOOD     16'h1D0F
`define SFR_ONES_STUFF   3'h5
`define SFR_ONES_ABORT   3'h7
`define SFR_DLY_FULL     3'h7
`define SFR_LEN_BASE     4'h5
`endif

// file: hdl/sfr_receiver.v
`include "sfr_defines.vh"
`default_nettype none
module sfr_receiver #(
  parameter DEPTH = 3,
  parameter AW    = 2
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_clk_pin,
  input  wire        rx_data_pin,
  input  wire        carrier_detect_input,
  output reg         irq_out,
  output reg         rx_ready_out
);
  localparam ST_HUNT = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_SKIP = 2'h3;

  reg  [7:0]    line_mode_register;
  reg  [7:0]    interrupt_control_register;
  reg  [7:0]    rx_ctrl_reg;
  reg  [7:0]    secondary_address_register;
  reg  [7:0]    flag_pattern_register;
  reg  [2:0]    clk_sync_reg;
  reg  [1:0]    dat_sync_reg;
  reg  [2:0]    cd_sync_reg;
  reg  [1:0]    state_reg;
  reg  [7:0]    raw_reg;
  reg  [2:0]    ones_reg;
  reg  [6:0]    dly_reg;
  reg  [2:0]    dly_cnt_reg;
  reg  [7:0]    chr_reg;
  reg  [2:0]    bit_cnt_reg;
  reg           got_char_reg;
  reg  [15:0]   crc_reg;
  reg           abort_reg;
  reg           overrun_reg;
  reg           eof_reg;
  reg           crc_err_reg;
  reg  [2:0]    residue_reg;
  reg           ext_pend_reg;
  reg           armed_reg;
  reg           first_pend_reg;
  reg  [7:0]    fifo_mem [0:DEPTH-1];
  reg  [AW-1:0] wr_ptr_reg;
  reg  [AW-1:0] rd_ptr_reg;
  reg  [AW:0]   count_reg;

  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1)
        ptr_inc = {AW{1'b0}};
      else
        ptr_inc = p + 1'b1;
    end
  endfunction

  function reg_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      reg_hit = (a == target);
    end
  endfunction

  wire         apb_do    = psel & penable & pready;
  wire         apb_wr    = apb_do & pwrite;
  wire         apb_rd    = apb_do & ~pwrite;
  wire         cmd_wr    = apb_wr & reg_hit(paddr, `SFR_A_CMD);
  wire         err_rst   = cmd_wr & pwdata[`SFR_CMD_ERR_RST];
  wire         ext_rst   = cmd_wr & pwdata[`SFR_CMD_EXT_RST];
  wire         arm_cmd   = cmd_wr & pwdata[`SFR_CMD_ARM];
  wire         hunt_cmd  = apb_wr & reg_hit(paddr, `SFR_A_RX_CTRL)
                         & pwdata[`SFR_RC_HUNT];
  wire         pop       = apb_rd & reg_hit(paddr, `SFR_A_DATA)
                         & (count_reg != {(AW+1){1'b0}});
  wire         rx_on     = rx_ctrl_reg[`SFR_RC_EN]
                         & line_mode_register[`SFR_LM_SDLC];
  wire [1:0]   int_mode  = interrupt_control_register[`SFR_IC_MODE_HI:
                                                      `SFR_IC_MODE_LO];
  wire [3:0]   char_len  = `SFR_LEN_BASE
                         + {2'h0, rx_ctrl_reg[`SFR_RC_LEN_HI:`SFR_RC_LEN_LO]};
  wire         bit_evt   = clk_sync_reg[1] & ~clk_sync_reg[2];
  wire         din       = dat_sync_reg[1];
  wire         cd_change = cd_sync_reg[1] ^ cd_sync_reg[2];
  wire [7:0]   raw_next  = {raw_reg[6:0], din};
  wire         fifo_full = (count_reg == DEPTH[AW:0]);
  wire         in_frame  = (state_reg == ST_ADDR) | (state_reg == ST_DATA);

  reg          flag_det;
  reg          stuff_del;
  reg  [2:0]   ones_next;
  reg          abort_set;
  reg          deliver;
  reg          dbit;
  reg  [7:0]   chr_next;
  reg          char_done;
  reg  [7:0]   char_out;
  reg  [15:0]  crc_next;
  reg          push;
  reg          addr_ok;

  always @* begin
    flag_det  = bit_evt & (raw_next == flag_pattern_register);
    stuff_del = bit_evt & ~din & (ones_reg == `SFR_ONES_STUFF);
    if (~din)
      ones_next = 3'h0;
    else if (ones_reg == `SFR_ONES_ABORT)
      ones_next = ones_reg;
    else
      ones_next = ones_reg + 3'h1;
    abort_set = bit_evt & (ones_next == `SFR_ONES_ABORT);
    deliver   = bit_evt & in_frame & ~flag_det & ~stuff_del & ~abort_set
              & (dly_cnt_reg == `SFR_DLY_FULL);
    dbit      = dly_reg[6];
    chr_next  = {dbit, chr_reg[7:1]};
    char_done = deliver & ({1'b0, bit_cnt_reg} + 4'h1 >= char_len);
    char_out  = chr_next >> (4'h8 - char_len);
    crc_next  = {crc_reg[14:0], 1'b0}
              ^ ((crc_reg[15] ^ dbit) ? `SFR_CRC_POLY : 16'h0000);
    addr_ok   = (char_out == secondary_address_register)
              | (char_out == `SFR_GLOBAL_ADDR);
    push      = char_done & ((state_reg == ST_DATA) | addr_ok);
  end

  // synchronisers: first stage feeds only the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync_reg <= 3'h0;
      dat_sync_reg <= 2'h0;
      cd_sync_reg  <= 3'h0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], rx_clk_pin};
      dat_sync_reg <= {dat_sync_reg[0], rx_data_pin};
      cd_sync_reg  <= {cd_sync_reg[1:0], carrier_detect_input};
    end
  end

  // control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_mode_register         <= 8'h00;
      interrupt_control_register <= 8'h00;
      rx_ctrl_reg                <= 8'h00;
      secondary_address_register <= 8'h00;
      flag_pattern_register      <= `SFR_FLAG_RST;
    end else if (apb_wr) begin
      if (reg_hit(paddr, `SFR_A_LINE_MODE))
        line_mode_register <= pwdata[7:0];
      if (reg_hit(paddr, `SFR_A_INT_CTRL))
        interrupt_control_register <= pwdata[7:0];
      if (reg_hit(paddr, `SFR_A_RX_CTRL))
        rx_ctrl_reg <= {3'h0, 1'b0, pwdata[3:0]};
      if (reg_hit(paddr, `SFR_A_SEC_ADDR))
        secondary_address_register <= pwdata[7:0];
      if (reg_hit(paddr, `SFR_A_FLAG))
        flag_pattern_register <= pwdata[7:0];
    end
  end

  // frame engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_HUNT;
      raw_reg      <= 8'h00;
      ones_reg     <= 3'h0;
      dly_reg      <= 7'h00;
      dly_cnt_reg  <= 3'h0;
      chr_reg      <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      got_char_reg <= 1'b0;
      crc_reg      <= `SFR_CRC_INIT;
      abort_reg    <= 1'b0;
      eof_reg      <= 1'b0;
      crc_err_reg  <= 1'b0;
      residue_reg  <= 3'h0;
    end else begin
      if (bit_evt) begin
        raw_reg  <= raw_next;
        ones_reg <= ones_next;
        if (abort_set)
          abort_reg <= 1'b1;
        else if (~din)
          abort_reg <= 1'b0;
      end
      if (~rx_on || hunt_cmd) begin
        state_reg <= ST_HUNT;
      end else if (flag_det) begin
        if (in_frame && got_char_reg) begin
          eof_reg     <= 1'b1;
          crc_err_reg <= (crc_reg != `SFR_CRC_GOOD);
          residue_reg <= bit_cnt_reg;
        end
        if (state_reg != ST_DATA || got_char_reg)
          state_reg <= interrupt_control_register[`SFR_IC_ADDR_SRCH]
                     ? ST_ADDR : ST_DATA;
        dly_cnt_reg  <= 3'h0;
        bit_cnt_reg  <= 3'h0;
        got_char_reg <= 1'b0;
        crc_reg      <= `SFR_CRC_INIT;
      end else if (abort_set) begin
        if (in_frame)
          state_reg <= ST_SKIP;
      end else if (bit_evt && in_frame && !stuff_del) begin
        dly_reg <= {dly_reg[5:0], din};
        if (dly_cnt_reg != `SFR_DLY_FULL)
          dly_cnt_reg <= dly_cnt_reg + 3'h1;
      end
      if (deliver && rx_on && !hunt_cmd) begin
        crc_reg <= crc_next;
        if (char_done) begin
          chr_reg      <= 8'h00;
          bit_cnt_reg  <= 3'h0;
          got_char_reg <= 1'b1;
          if (state_reg == ST_ADDR)
            state_reg <= addr_ok ? ST_DATA : ST_SKIP;
        end else begin
          chr_reg     <= chr_next;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
      end
      if (push)
        eof_reg <= 1'b0;
      if (err_rst && !(flag_det && in_frame && got_char_reg)) begin
        eof_reg     <= 1'b0;
        crc_err_reg <= 1'b0;
      end
    end
  end

  // receive FIFO
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg  <= {AW{1'b0}};
      rd_ptr_reg  <= {AW{1'b0}};
      count_reg   <= {(AW+1){1'b0}};
      overrun_reg <= 1'b0;
    end else begin
      if (push && rx_on && !hunt_cmd && (!fifo_full || pop)) begin
        fifo_mem[wr_ptr_reg] <= char_out;
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop)
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      if (push && rx_on && !hunt_cmd && (!fifo_full || pop) && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !(push && rx_on && !hunt_cmd))
        count_reg <= count_reg - 1'b1;
      if (push && fifo_full && !pop)
        overrun_reg <= 1'b1;
      else if (err_rst)
        overrun_reg <= 1'b0;
    end
  end

  // interrupt sources
  wire special = (overrun_reg | eof_reg)
               & (int_mode == `SFR_MODE_FIRST
                  | int_mode == `SFR_MODE_EVERY);
  wire rx_int  = (int_mode == `SFR_MODE_EVERY)
               ? (count_reg != {(AW+1){1'b0}})
               : ((int_mode == `SFR_MODE_FIRST) & first_pend_reg);
  wire ext_evt = cd_change
               | (bit_evt & abort_set & ~abort_reg)
               | (bit_evt & ~din & abort_reg);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_pend_reg   <= 1'b0;
      armed_reg      <= 1'b1;
      first_pend_reg <= 1'b0;
      irq_out        <= 1'b0;
      rx_ready_out   <= 1'b0;
    end else begin
      if (ext_evt && interrupt_control_register[`SFR_IC_EXT_EN])
        ext_pend_reg <= 1'b1;
      else if (ext_rst)
        ext_pend_reg <= 1'b0;
      if (push && armed_reg) begin
        armed_reg      <= 1'b0;
        first_pend_reg <= 1'b1;
      end else begin
        if (arm_cmd)
          armed_reg <= 1'b1;
        if (pop)
          first_pend_reg <= 1'b0;
      end
      irq_out      <= ext_pend_reg | special | rx_int;
      rx_ready_out <= (count_reg != {(AW+1){1'b0}});
    end
  end

  // apb slave: one wait state, answer registered
  reg [31:0] rd_val;
  reg        addr_ok_bus;
  reg [2:0]  vec_code;
  always @* begin
    if (!interrupt_control_register[`SFR_IC_SAV])
      vec_code = 3'h0;
    else if (special)
      vec_code = 3'h3;
    else if (rx_int)
      vec_code = 3'h2;
    else if (ext_pend_reg)
      vec_code = 3'h1;
    else
      vec_code = 3'h0;
    addr_ok_bus = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `SFR_A_LINE_MODE: rd_val = {24'h0, line_mode_register};
      `SFR_A_INT_CTRL:  rd_val = {24'h0, interrupt_control_register};
      `SFR_A_RX_CTRL:   rd_val = {24'h0, rx_ctrl_reg};
      `SFR_A_SEC_ADDR:  rd_val = {24'h0, secondary_address_register};
      `SFR_A_FLAG:      rd_val = {24'h0, flag_pattern_register};
      `SFR_A_CMD:       rd_val = 32'h0000_0000;
      `SFR_A_STAT1:     rd_val = {28'h0, abort_reg, state_reg == ST_HUNT,
                                  cd_sync_reg[2],
                                  count_reg != {(AW+1){1'b0}}};
      `SFR_A_STAT2:     rd_val = {25'h0, residue_reg, 1'b0, eof_reg,
                                  crc_err_reg, overrun_reg};
      `SFR_A_DATA:      rd_val = {24'h0, fifo_mem[rd_ptr_reg]};
      `SFR_A_INT_STAT:  rd_val = {25'h0, vec_code, 1'b0, special,
                                  rx_int, ext_pend_reg};
      default:          addr_ok_bus = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= ~addr_ok_bus;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/sfr_receiver_props.sv
`default_nettype none
module sfr_receiver_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_clk_pin,
  input wire logic        rx_data_pin,
  input wire logic        carrier_detect_input,
  input wire logic        irq_out,
  input wire logic        rx_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ic_reg;
  logic       ovr_reg;
  // shadow of interrupt control and of an overrun seen by a read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ic_reg  <= 8'h00;
      ovr_reg <= 1'b0;
    end else if (pready && !pslverr && pwrite) begin
      if (paddr == 8'h04) ic_reg <= pwdata[7:0];
      if (paddr == 8'h14 && pwdata[0]) ovr_reg <= 1'b0;
    end else if (pready && paddr == 8'h1C && prdata[0]) begin
      ovr_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait state");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_unmapped_err: assert property (
    psel && penable && !pready && paddr > 8'h24 |=> pslverr)
    else $error("unmapped access not refused");
  chk_overrun_sticky: assert property (
    pready && !pwrite && paddr == 8'h1C && ovr_reg |-> prdata[0])
    else $error("overrun bit lost before error reset");
  chk_every_irq: assert property (
    ic_reg[4:3] == 2'h2 && rx_ready_out |-> ##[0:3] irq_out)
    else $error("stored character without interrupt");
  chk_quiet_irq: assert property (
    (ic_reg[4:3] == 2'h0 && !ic_reg[0]) [*3] |-> !irq_out)
    else $error("interrupt with all sources off");
  chk_carrier_irq: assert property (
    ic_reg[0] && $changed(carrier_detect_input) |-> ##[1:8] irq_out)
    else $error("carrier change without interrupt");
endmodule
`default_nettype wire

// file: tb/sfr_station.sv
`default_nettype none
module sfr_station (
  output var logic clk_o,
  output var logic data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    clk_o  = 1'b0;
    data_o = 1'b1;
  end
  // one bit; the clock stands still outside frames
  task automatic put(input logic b);
    data_o = b;
    #200 clk_o = 1'b1;
    #400 clk_o = 1'b0;
    #200 data_o = ~b;
  endtask
  task automatic raw(input logic [7:0] v);
    for (int i = 0; i < 8; i++) put(v[i]);
  endtask
  function automatic logic [15:0] fcs_of(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) for (int k = 0; k < 8; k++)
      c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? 16'h8408 : 16'h0000);
    return ~c;
  endfunction
  // flag, bytes lsb first with zero insertion, flag
  task automatic frame(input logic [7:0] q[$]);
    int ones;
    ones = 0;
    raw(8'h7E);
    foreach (q[i]) for (int k = 0; k < 8; k++) begin
      put(q[i][k]);
      ones = q[i][k] ? ones + 1 : 0;
      if (ones == 5) begin
        put(1'b0);
        ones = 0;
      end
    end
    raw(8'h7E);
  endtask
endmodule
`default_nettype wire

// file: tb/test_sdlc_frame_receiver.sv
`default_nettype none
module test_sdlc_frame_receiver;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_clk_pin, rx_data_pin, carrier_detect_input;
  logic        irq_out, rx_ready_out, rd_e, drain;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [7:0]  expq[$];
  int          bad_count, compares;
  sfr_receiver dut (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .rx_clk_pin           (rx_clk_pin),
    .rx_data_pin          (rx_data_pin),
    .carrier_detect_input (carrier_detect_input),
    .irq_out              (irq_out),
    .rx_ready_out         (rx_ready_out)
  );
  sfr_station  stn (.clk_o(rx_clk_pin), .data_o(rx_data_pin));
  task automatic wrap_up;
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      wrap_up();
    end
    rd_v = prdata;
    rd_e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, m, e);
    apb(1'b0, a, 8'h00);
    chk(rd_v & {24'h000000, m}, {24'h000000, e});
  endtask
  task automatic send(input logic [7:0] q[$], input int keep,
                      input logic bad);
    logic [15:0] f;
    f = stn.fcs_of(q) ^ {15'h0000, bad};
    q.push_back(f[7:0]);
    q.push_back(f[15:8]);
    foreach (q[i]) if (i < keep) expq.push_back(q[i]);
    stn.frame(q);
    repeat (8) @(posedge pclk);
  endtask
  task automatic settle;
    int n;
    n = 0;
    while (expq.size() > 0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      bad_count++;
      wrap_up();
    end
    repeat (6) @(posedge pclk);
    drain = 1'b0;
  endtask
  // drains the receive data while enabled and compares in order
  initial forever begin
    @(posedge pclk);
    if (drain === 1'b1 && rx_ready_out === 1'b1) begin
      apb(1'b0, 8'h20, 8'h00);
      if (expq.size() == 0) chk(rd_v, 32'hFFFFFFFF);
      else chk(rd_v, {24'h000000, expq.pop_front()});
      @(posedge pclk);
    end
  end
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    carrier_detect_input = 1'b0;
    drain = 1'b0;
    void'($urandom(32'h11F3));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h10, 8'hFF, 8'h7E);
    apb(1'b0, 8'h30, 8'h00);
    chk({31'h0, rd_e}, 32'h1);
    chk(rd_v, 32'h0);
    wr(8'h00, 8'h02);
    wr(8'h0C, 8'h5A);
    wr(8'h10, 8'h7E);
    wr(8'h04, 8'h14);
    wr(8'h08, 8'h07);
    rdc(8'h18, 8'h04, 8'h04);
    drain = 1'b1;
    send('{8'h5A, 8'h7E, 8'hFF, 8'($urandom)}, 99, 1'b0);
    settle();
    rdc(8'h1C, 8'h77, 8'h04);
    rdc(8'h18, 8'h04, 8'h00);
    drain = 1'b1;
    send('{8'hFF, 8'($urandom)}, 99, 1'b1);
    settle();
    rdc(8'h1C, 8'h06, 8'h06);
    wr(8'h08, 8'h17);
    rdc(8'h18, 8'h04, 8'h04);
    drain = 1'b1;
    send('{8'h33, 8'h01}, 0, 1'b0);
    send('{8'h5A, 8'h00, 8'h3E}, 99, 1'b0);
    settle();
    send('{8'h5A, 8'h01, 8'h02, 8'h03}, 3, 1'b0);
    rdc(8'h1C, 8'h01, 8'h01);
    rdc(8'h1C, 8'h01, 8'h01);
    wr(8'h14, 8'h01);
    rdc(8'h1C, 8'h01, 8'h00);
    drain = 1'b1;
    settle();
    // first-character mode: rearm, one frame held, then drained
    wr(8'h04, 8'h0C);
    wr(8'h14, 8'h04);
    send('{8'h5A}, 99, 1'b0);
    rdc(8'h24, 8'h02, 8'h02);
    drain = 1'b1;
    settle();
    rdc(8'h24, 8'h02, 8'h00);
    wr(8'h04, 8'h15);
    @(posedge pclk);
    carrier_detect_input <= 1'b1;
    repeat (12) @(posedge pclk);
    rdc(8'h24, 8'h01, 8'h01);
    wr(8'h14, 8'h02);
    stn.raw(8'hFF);
    rdc(8'h18, 8'h08, 8'h08);
    rdc(8'h24, 8'h01, 8'h01);
    wr(8'h14, 8'h02);
    stn.raw(8'h7E);
    repeat (8) @(posedge pclk);
    rdc(8'h24, 8'h01, 8'h01);
    wrap_up();
  end
endmodule
bind sfr_receiver sfr_receiver_props chk (.*);
`default_nettype wire
